/* File: test/mbc_bus_dev.sv */
// Bus device model: panels and detectors that write master-trigger telegrams.
// Assumes the mclk domain; a slave ON of block 2 is relayed to block 1.
module mbc_bus_dev (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Slave telegram and bench requests
  input wire logic slv_on,
  input wire logic [4:0] req_wr,
  input wire logic [4:0] req_val,
  // Master-trigger telegrams
  output logic [4:0] mtrig_wr,
  output logic [4:0] mtrig_val
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [4:0] fwd = {3'h0, slv_on, 1'b0};
  // Idle value line toggles so a stale value is never mistaken for a telegram
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mtrig_wr <= 5'h00;
      mtrig_val <= 5'h00;
    end else begin
      mtrig_wr <= req_wr | fwd;
      mtrig_val <= (req_wr | fwd) != 5'h00 ? (req_val | fwd) : ~mtrig_val;
    end
  end
endmodule : mbc_bus_dev

/* File: test/mbc_ctrl_properties.sv */
// Checker for the movement block control top; asserts on block 0, covers blocks 0 and 2.
// Assumes a bind from the bench and one clock domain.
`include "mbc_defs.svh"
module mbc_ctrl_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched ports
  input wire logic [2*`MBC_NBLK-1:0] mode,
  input wire logic [2*`MBC_NBLK-1:0] bout_mode,
  input wire logic [`MBC_NBLK-1:0] bri_dep,
  input wire logic [`MBC_NBLK-1:0] move,
  input wire logic [`MBC_NBLK-1:0] move_start,
  input wire logic [`MBC_NBLK-1:0] tx_on,
  input wire logic [`MBC_NBLK-1:0] tx_off,
  input wire logic [`MBC_NBLK-1:0] bout_tx,
  input wire logic [`MBC_NBLK-1:0] light_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire logic nrm = mode[1:0] == mbc_pkg::MBC_NORMAL;
  walk_start_a: assert property (nrm && !bri_dep[0] && move_start[0] && !light_on[0] |=> tx_on[0] && light_on[0])
    else $error("no ON after start");
  normal_cause_a: assert property (nrm && tx_on[0] |-> $past(move_start[0]))
    else $error("ON without start in normal mode");
  on_lights_a: assert property (tx_on[0] && !mode[1] |-> light_on[0])
    else $error("ON without light");
  on_single_a: assert property (nrm && tx_on[0] |=> !tx_on[0])
    else $error("repeated ON in normal mode");
  hold_light_a: assert property (nrm && light_on[0] && move[0] |=> light_on[0])
    else $error("light dropped during movement");
  off_ends_a: assert property (nrm && $fell(light_on[0]) |-> tx_off[0] || $past(tx_off[0]))
    else $error("light ended without OFF");
  on_off_excl_a: assert property (!(tx_on[0] && tx_off[0]))
    else $error("ON and OFF together");
  bout_none_a: assert property (bout_mode[1:0] == mbc_pkg::MBC_BO_OFF |-> !bout_tx[0])
    else $error("brightness bit sent while off");
  cover property (tx_on[0]);
  cover property ($fell(light_on[0]));
  cover property (tx_on[2] ##1 !tx_on[2]);
endmodule : mbc_ctrl_properties

/* File: test/mbc_ctrl_tb_top.sv */
// Bench for the movement block control top with a bus device model.
// Assumes design, package, bus model and checker are compiled before it.
module mbc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  // Low light: the default threshold reads dark
  logic [15:0] lux = 16'h0064;
  logic [15:0] thr_wdata = 16'h000A;
  logic [9:0] mode = 10'h000;
  logic [9:0] bout_mode = 10'h154;
  logic [4:0] bri_dep = 5'h00, adark_en = 5'h00, adark_lvl = 5'h00, thr_obj_en = 5'h00, trig_off_en = 5'h00;
  logic [4:0] move = 5'h00, adark_val = 5'h00, trig_val = 5'h00, mreq_val = 5'h00, like_presence = 5'h00;
  logic [4:0] use_pot = 5'h00;
  // Strobes: move_start, thr_wr, adark_wr, trig_wr, bus request
  logic [4:0] stb [5] = '{default: 5'h00};
  logic [4:0] mtrig_wr, mtrig_val, tx_on, tx_off, bout_tx, bout_val, light_on;
  int failures = 0;
  int n_tests = 0;
  always #4 mclk = ~mclk;
  mbc_ctrl mbc_ctrl_i (.mclk(mclk), .rst_n(rst_n), .lux(lux), .pot_thr({5{16'h0082}}), .par_thr({5{16'h0082}}),
    .pause_s(7'h04), .mode(mode), .bri_dep(bri_dep), .use_pot(use_pot), .thr_obj_en(thr_obj_en),
    .hyst_pct({5{7'h19}}), .bout_mode(bout_mode), .adark_en(adark_en), .adark_lvl(adark_lvl),
    .like_presence(like_presence), .trig_off_en(trig_off_en), .stair_cyc({5{32'h00000014}}),
    .cycle_cyc({5{32'h00000008}}), .move(move), .move_start(stb[0]), .thr_wr(stb[1]), .thr_wdata(thr_wdata),
    .adark_wr(stb[2]), .adark_val(adark_val), .mtrig_wr(mtrig_wr), .mtrig_val(mtrig_val), .trig_wr(stb[3]),
    .trig_val(trig_val), .tx_on(tx_on), .tx_off(tx_off), .bout_tx(bout_tx), .bout_val(bout_val), .light_on(light_on));
  mbc_bus_dev mbc_bus_dev_i (.mclk(mclk), .rst_n(rst_n), .slv_on(tx_on[2]), .req_wr(stb[4]), .req_val(mreq_val),
    .mtrig_wr(mtrig_wr), .mtrig_val(mtrig_val));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle strobe; returns settled just after the answering edge
  task pls(input int k, input int b);
    @(posedge mclk) stb[k][b] <= 1'b1;
    @(posedge mclk) stb[k][b] <= 1'b0;
    #1;
  endtask : pls
  task automatic cnt(input int b, input int n, output int on, output int off);
    on = 0;
    off = 0;
    repeat (n) begin
      @(posedge mclk) #1;
      on += tx_on[b];
      off += tx_off[b];
    end
  endtask : cnt
  task automatic t_indep();
    int on, off;
    @(posedge mclk) move[0] <= 1'b1;
    pls(0, 0);
    chk(tx_on[0], 1'b1);
    chk(light_on[0], 1'b1);
    @(posedge mclk) move[0] <= 1'b0;
    repeat (10) @(posedge mclk);
    move[0] <= 1'b1;
    pls(0, 0);
    chk(tx_on[0], 1'b0);
    @(posedge mclk) move[0] <= 1'b0;
    cnt(0, 15, on, off);
    chk(off, 0);
    cnt(0, 30, on, off);
    chk(off, 1);
    chk(light_on[0], 1'b0);
    $display("t_indep done");
  endtask : t_indep
  task automatic t_dep();
    @(posedge mclk) bri_dep[0] <= 1'b1;
    thr_obj_en[0] <= 1'b1;
    move[0] <= 1'b1;
    pls(1, 0);
    pls(0, 0);
    chk(tx_on[0], 1'b0);
    @(posedge mclk) adark_en[0] <= 1'b1;
    adark_lvl[0] <= 1'b1;
    pls(2, 0);
    pls(0, 0);
    chk(tx_on[0], 1'b0);
    @(posedge mclk) adark_lvl[0] <= 1'b0;
    pls(2, 0);
    pls(0, 0);
    chk(tx_on[0], 1'b1);
    @(posedge mclk) adark_en[0] <= 1'b0;
    pls(0, 0);
    chk(light_on[0], 1'b1);
    @(posedge mclk) move[0] <= 1'b0;
    bri_dep[0] <= 1'b0;
    repeat (40) @(posedge mclk);
    chk(light_on[0], 1'b0);
    $display("t_dep done");
  endtask : t_dep
  task automatic t_trig();
    @(posedge mclk) trig_val[0] <= 1'b1;
    pls(3, 0);
    chk(tx_on[0], 1'b0);
    @(posedge mclk) mode[1:0] <= mbc_pkg::MBC_MASTER;
    trig_off_en[0] <= 1'b1;
    pls(3, 0);
    chk(tx_on[0], 1'b1);
    @(posedge mclk) trig_val[0] <= 1'b0;
    pls(3, 0);
    repeat (3) @(posedge mclk);
    chk(light_on[0], 1'b0);
    mode[1:0] <= mbc_pkg::MBC_NORMAL;
    $display("t_trig done");
  endtask : t_trig
  task automatic t_slave();
    int on, off;
    // Block 2 slave, block 1 master
    @(posedge mclk) mode[5:2] <= 4'h9;
    pls(4, 1);
    repeat (2) @(posedge mclk);
    #1;
    chk(light_on[1], 1'b0);
    move[2] <= 1'b1;
    pls(0, 2);
    cnt(2, 30, on, off);
    chk(on >= 3, 1'b1);
    chk(light_on[1], 1'b1);
    @(posedge mclk) move[2] <= 1'b0;
    cnt(2, 10, on, off);
    cnt(2, 20, on, off);
    chk(on + off, 0);
    $display("t_slave done");
  endtask : t_slave
  task automatic t_mon();
    int on, off;
    @(posedge mclk) mode[7:6] <= mbc_pkg::MBC_MONITOR;
    move[3] <= 1'b1;
    pls(0, 3);
    cnt(3, 24, on, off);
    chk(on >= 2, 1'b1);
    @(posedge mclk) move[3] <= 1'b0;
    cnt(3, 60, on, off);
    chk(off >= 2, 1'b1);
    $display("t_mon done");
  endtask : t_mon
  // Threshold write to block 4; returns once the brightness bit has followed
  task automatic wr4(input logic [15:0] v);
    @(posedge mclk) thr_wdata <= v;
    pls(1, 4);
    repeat (2) @(posedge mclk);
    #1;
  endtask : wr4
  task automatic t_thr();
    @(posedge mclk) bri_dep[4] <= 1'b1;
    move[4] <= 1'b1;
    wr4(16'h0046);
    chk(bout_val[4], 1'b1);
    @(posedge mclk) thr_obj_en[4] <= 1'b1;
    wr4(16'h0046);
    chk(bout_val[4], 1'b0);
    chk(bout_val[3], 1'b1);
    wr4(16'h0065);
    chk(bout_val[4], 1'b1);
    wr4(16'h005A);
    chk(bout_val[4], 1'b1);
    wr4(16'h0046);
    chk(bout_val[4], 1'b0);
    @(posedge mclk) use_pot[4] <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(bout_val[4], 1'b1);
    chk(light_on[4], 1'b0);
    @(posedge mclk) like_presence[4] <= 1'b1;
    lux <= 16'h1388;
    repeat (2) @(posedge mclk);
    #1;
    chk(light_on[4], 1'b1);
    chk(bout_val[4], 1'b1);
    $display("t_thr done");
  endtask : t_thr
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_indep();
    t_dep();
    t_trig();
    t_slave();
    t_mon();
    t_thr();
    end_of_test();
  end
  // Tests take about 330 cycles; far longer means a hang
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule : mbc_ctrl_tb_top
bind mbc_ctrl mbc_ctrl_properties mbc_ctrl_properties_i (.mclk, .rst_n, .mode, .bout_mode, .bri_dep, .move,
  .move_start, .tx_on, .tx_off, .bout_tx, .light_on);

/* File: verilog/mbc_cmp.sv */
// Per-block threshold store and hysteresis comparator.
// Assumes lux and potentiometer inputs are already in the mclk domain.
`include "mbc_defs.svh"
module mbc_cmp (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Measurement
  input wire logic [15:0] lux,
  input wire logic [16*`MBC_NBLK-1:0] pot_thr,
  input wire logic [16*`MBC_NBLK-1:0] par_thr,
  input wire logic [`MBC_NBLK-1:0] use_pot,
  input wire logic [`MBC_NBLK-1:0] thr_obj_en,
  input wire logic [`MBC_NBLK-1:0] thr_wr,
  input wire logic [15:0] thr_wdata,
  input wire logic [7*`MBC_NBLK-1:0] hyst_pct,
  input wire logic [6:0] pause_s,
  // Dark decisions
  mbc_dark_if.cmp dk
);
  logic [26:0] tick_r;
  logic [6:0] sec_r;
  logic meas_r;
  logic [15:0] lux_r;
  logic [6:0] pause_c;
  wire sec_tick = (tick_r == 27'(`MBC_SEC_CYC - 1));
  // Out-of-range pause falls back to the default
  assign pause_c = (pause_s < `MBC_PAUSE_MIN || pause_s > `MBC_PAUSE_MAX) ? `MBC_PAUSE_DEF : pause_s;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 27'h0000000;
      sec_r <= 7'h00;
      // First measurement right after reset, else no decision for a whole pause
      meas_r <= 1'b1;
      lux_r <= 16'hFFFF;
    end else begin
      tick_r <= sec_tick ? 27'h0000000 : tick_r + 27'h0000001;
      meas_r <= sec_tick && (sec_r + 7'h01 >= pause_c);
      if (sec_tick) sec_r <= (sec_r + 7'h01 >= pause_c) ? 7'h00 : sec_r + 7'h01;
      if (meas_r) lux_r <= lux;
    end
  end
  genvar g;
  generate
    for (g = 0; g < `MBC_NBLK; g++) begin : g_blk
      logic [15:0] thr_r;
      logic dark_r;
      logic [15:0] thr_sel;
      logic [6:0] hy;
      logic [22:0] band;
      logic [15:0] hi_lim;
      wire [15:0] wd_c = (thr_wdata < `MBC_LUX_MIN) ? `MBC_LUX_MIN :
                         (thr_wdata > `MBC_LUX_MAX) ? `MBC_LUX_MAX : thr_wdata;
      wire [15:0] par = par_thr[16*g +: 16];
      wire par_ok = par >= `MBC_LUX_MIN && par <= `MBC_LUX_MAX;
      assign hy = (hyst_pct[7*g +: 7] < `MBC_HYST_MIN || hyst_pct[7*g +: 7] > `MBC_HYST_MAX) ?
                  `MBC_HYST_DEF : hyst_pct[7*g +: 7];
      assign thr_sel = use_pot[g] ? pot_thr[16*g +: 16] : thr_r;
      assign band = 23'(({7'h00, thr_sel} * {16'h0000, hy}) / 23'd100);
      assign hi_lim = 16'(band) + thr_sel;
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          thr_r <= `MBC_LUX_DEF;
          dark_r <= 1'b0;
        end else begin
          if (thr_wr[g] && thr_obj_en[g]) thr_r <= wd_c;
          else if (dk.sample[g] && !thr_wr[g] && par_ok && thr_r == `MBC_LUX_DEF) thr_r <= par;
          if (lux_r < thr_sel) dark_r <= 1'b1;
          else if (lux_r > hi_lim) dark_r <= 1'b0;
        end
      end
      assign dk.dark[g] = dark_r;
    end
  endgenerate
endmodule : mbc_cmp

/* File: verilog/mbc_ctrl.sv */
// Top: five movement blocks with brightness gating and operating modes.
// Assumes movement, trigger and bus receive strobes are synchronous to mclk.
`include "mbc_defs.svh"
module mbc_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Brightness
  input wire logic [15:0] lux,
  input wire logic [16*`MBC_NBLK-1:0] pot_thr,
  input wire logic [16*`MBC_NBLK-1:0] par_thr,
  input wire logic [6:0] pause_s,
  // Per-block configuration
  input wire logic [2*`MBC_NBLK-1:0] mode,
  input wire logic [`MBC_NBLK-1:0] bri_dep,
  input wire logic [`MBC_NBLK-1:0] use_pot,
  input wire logic [`MBC_NBLK-1:0] thr_obj_en,
  input wire logic [7*`MBC_NBLK-1:0] hyst_pct,
  input wire logic [2*`MBC_NBLK-1:0] bout_mode,
  input wire logic [`MBC_NBLK-1:0] adark_en,
  input wire logic [`MBC_NBLK-1:0] adark_lvl,
  input wire logic [`MBC_NBLK-1:0] like_presence,
  input wire logic [`MBC_NBLK-1:0] trig_off_en,
  input wire logic [32*`MBC_NBLK-1:0] stair_cyc,
  input wire logic [32*`MBC_NBLK-1:0] cycle_cyc,
  // Movement and bus inputs
  input wire logic [`MBC_NBLK-1:0] move,
  input wire logic [`MBC_NBLK-1:0] move_start,
  input wire logic [`MBC_NBLK-1:0] thr_wr,
  input wire logic [15:0] thr_wdata,
  input wire logic [`MBC_NBLK-1:0] adark_wr,
  input wire logic [`MBC_NBLK-1:0] adark_val,
  input wire logic [`MBC_NBLK-1:0] mtrig_wr,
  input wire logic [`MBC_NBLK-1:0] mtrig_val,
  input wire logic [`MBC_NBLK-1:0] trig_wr,
  input wire logic [`MBC_NBLK-1:0] trig_val,
  // Telegram outputs
  output logic [`MBC_NBLK-1:0] tx_on,
  output logic [`MBC_NBLK-1:0] tx_off,
  output logic [`MBC_NBLK-1:0] bout_tx,
  output logic [`MBC_NBLK-1:0] bout_val,
  output logic [`MBC_NBLK-1:0] light_on
);
  mbc_dark_if dk ();
  mbc_cmp u_cmp (
    .mclk(mclk),
    .rst_n(rst_n),
    .lux(lux),
    .pot_thr(pot_thr),
    .par_thr(par_thr),
    .use_pot(use_pot),
    .thr_obj_en(thr_obj_en),
    .thr_wr(thr_wr),
    .thr_wdata(thr_wdata),
    .hyst_pct(hyst_pct),
    .pause_s(pause_s),
    .dk(dk.cmp)
  );
  genvar g;
  generate
    for (g = 0; g < `MBC_NBLK; g++) begin : g_blk
      mbc_pkg::mbc_state_e st_r, st_nxt;
      logic [31:0] tmr_r;
      logic [31:0] cyc_r;
      logic adark_r;
      logic dark_q_r;
      logic on_r, off_r, bt_r, bv_r, lit_r;
      mbc_pkg::mbc_mode_e md;
      mbc_pkg::mbc_bout_e bo;
      assign md = mbc_pkg::mbc_mode_e'(mode[2*g +: 2]);
      assign bo = mbc_pkg::mbc_bout_e'(bout_mode[2*g +: 2]);
      wire is_master = (md == mbc_pkg::MBC_MASTER);
      wire cyclic = (md == mbc_pkg::MBC_SLAVE) || (md == mbc_pkg::MBC_MONITOR);
      // Trigger objects exist only in master mode
      wire mt_on = is_master && mtrig_wr[g] && mtrig_val[g];
      wire tr_on = is_master && trig_wr[g] && trig_val[g];
      wire tr_off = is_master && trig_wr[g] && !trig_val[g] && trig_off_en[g];
      wire adark_act = adark_en[g] && (adark_r == adark_lvl[g]);
      wire dark_now = dk.dark[g] || adark_act;
      // Slaves evaluate without brightness; the master does the gating
      wire gate_used = bri_dep[g] && (md != mbc_pkg::MBC_SLAVE);
      // Triggers skip dead time: they need no move_start qualification
      wire dep_mv = move_start[g] || mt_on;
      // Presence style: darkness arriving while movement goes on also starts
      wire pres_mv = like_presence[g] && gate_used && move[g] && dark_now;
      wire start_ok = (dep_mv && (!gate_used || dark_now)) || tr_on || pres_mv;
      wire new_mv = move_start[g] || mt_on || tr_on;
      wire tmr_end = (tmr_r == 32'h00000001);
      wire cyc_end = (cyc_r == 32'h00000001);
      // Zero length would never reach the end count
      wire [31:0] stair = (stair_cyc[32*g +: 32] == 32'h00000000) ? 32'h00000001 : stair_cyc[32*g +: 32];
      wire [31:0] cycl = (cycle_cyc[32*g +: 32] == 32'h00000000) ? 32'h00000001 : cycle_cyc[32*g +: 32];
      wire mv_any = move[g] || new_mv;
      assign dk.sample[g] = move_start[g];
      always_comb begin
        st_nxt = st_r;
        case (st_r)
          mbc_pkg::MBC_IDLE: begin
            if (start_ok) st_nxt = mbc_pkg::MBC_ACTIVE;
          end
          mbc_pkg::MBC_ACTIVE: begin
            if (tr_off) st_nxt = mbc_pkg::MBC_IDLE;
            else if (!cyclic && tmr_end && !move[g] && !new_mv) st_nxt = mbc_pkg::MBC_IDLE;
            else if (cyclic && cyc_end && !mv_any) begin
              st_nxt = (md == mbc_pkg::MBC_MONITOR) ? mbc_pkg::MBC_AFTER : mbc_pkg::MBC_IDLE;
            end
          end
          mbc_pkg::MBC_AFTER: begin
            if (start_ok) st_nxt = mbc_pkg::MBC_ACTIVE;
          end
          default: st_nxt = mbc_pkg::MBC_IDLE;
        endcase
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          st_r <= mbc_pkg::MBC_IDLE;
          tmr_r <= 32'h00000000;
          cyc_r <= 32'h00000000;
          adark_r <= 1'b0;
          dark_q_r <= 1'b0;
          on_r <= 1'b0;
          off_r <= 1'b0;
          bt_r <= 1'b0;
          bv_r <= 1'b0;
          lit_r <= 1'b0;
        end else begin
          st_r <= st_nxt;
          if (adark_wr[g]) adark_r <= adark_val[g];
          on_r <= 1'b0;
          off_r <= 1'b0;
          // Brightness bit goes out only when the decision changes
          dark_q_r <= dark_now;
          bt_r <= (bo != mbc_pkg::MBC_BO_OFF) && (dark_now != dark_q_r);
          bv_r <= (bo == mbc_pkg::MBC_BO_INV) ? !dark_now : dark_now;
          if (st_r != mbc_pkg::MBC_ACTIVE && st_nxt == mbc_pkg::MBC_ACTIVE) begin
            on_r <= 1'b1;
            lit_r <= 1'b1;
            tmr_r <= stair;
            cyc_r <= cycl;
          end else if (st_r == mbc_pkg::MBC_ACTIVE) begin
            // Brightness no longer consulted while active
            if (new_mv || move[g]) tmr_r <= stair;
            else if (tmr_r != 32'h00000000) tmr_r <= tmr_r - 32'h00000001;
            if (cyc_end || cyc_r == 32'h00000000) begin
              cyc_r <= cycl;
              if (cyclic && mv_any) on_r <= 1'b1;
            end else begin
              cyc_r <= cyc_r - 32'h00000001;
            end
            if (st_nxt == mbc_pkg::MBC_IDLE) begin
              off_r <= (md != mbc_pkg::MBC_SLAVE);
              lit_r <= 1'b0;
            end
            if (st_nxt == mbc_pkg::MBC_AFTER) begin
              off_r <= 1'b1;
              lit_r <= 1'b0;
              cyc_r <= cycl;
            end
          end else if (st_r == mbc_pkg::MBC_AFTER) begin
            if (cyc_end) begin
              off_r <= 1'b1;
              cyc_r <= cycl;
            end else if (cyc_r != 32'h00000000) begin
              cyc_r <= cyc_r - 32'h00000001;
            end
          end
        end
      end
      assign tx_on[g] = on_r;
      assign tx_off[g] = off_r;
      assign bout_tx[g] = bt_r;
      assign bout_val[g] = bv_r;
      assign light_on[g] = lit_r;
    end
  endgenerate
endmodule : mbc_ctrl

/* File: verilog/mbc_dark_if.sv */
// Carries the dark decision from the comparator into the block control.
// Assumes one clock domain.
`include "mbc_defs.svh"
interface mbc_dark_if;
  logic [`MBC_NBLK-1:0] dark;
  logic [`MBC_NBLK-1:0] sample;
  modport cmp (output dark, input sample);
  modport ctl (input dark, output sample);
endinterface : mbc_dark_if

/* File: verilog/mbc_defs.svh */
// Constants for the movement block brightness and mode control.
// Assumes a single 125 MHz clock; no other files needed.
`ifndef MBC_DEFS_SVH
`define MBC_DEFS_SVH
`define MBC_NBLK 5
`define MBC_LUX_MIN 16'h000A
`define MBC_LUX_MAX 16'h07D0
`define MBC_LUX_DEF 16'h0082
`define MBC_HYST_MIN 7'h0A
`define MBC_HYST_MAX 7'h32
`define MBC_HYST_DEF 7'h19
`define MBC_PAUSE_MIN 7'h01
`define MBC_PAUSE_MAX 7'h78
`define MBC_PAUSE_DEF 7'h04
`define MBC_CLK_HZ 125000000
`define MBC_SEC_CYC (`MBC_CLK_HZ)
`endif

/* File: verilog/mbc_pkg.sv */
// Types for the movement block control.
// Assumes mbc_defs.svh for the numeric constants.
package mbc_pkg;
  typedef enum logic [1:0] {
    MBC_NORMAL = 2'h0,
    MBC_MASTER = 2'h1,
    MBC_SLAVE = 2'h2,
    MBC_MONITOR = 2'h3
  } mbc_mode_e;
  typedef enum logic [1:0] {
    MBC_BO_OFF = 2'h0,
    MBC_BO_NORM = 2'h1,
    MBC_BO_INV = 2'h2
  } mbc_bout_e;
  typedef enum logic [1:0] {
    MBC_IDLE = 2'h0,
    MBC_ACTIVE = 2'h1,
    MBC_AFTER = 2'h2
  } mbc_state_e;
endpackage : mbc_pkg
